// ---- rtl/dram_init_pkg.sv ----
// Constants shared by the mode-register and power-up sequence tracker.
package dram_init_pkg;
  localparam int unsigned ADDR_W       = 15;
  localparam int unsigned REG_ADDR_W   = 8;
  localparam int unsigned DATA_W       = 32;
  // Register byte offsets.
  localparam logic [7:0] OFS_MR        = 8'h00;
  localparam logic [7:0] OFS_EMR1      = 8'h04;
  localparam logic [7:0] OFS_EMR2      = 8'h08;
  localparam logic [7:0] OFS_EMR3      = 8'h0C;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_CONTROL   = 8'h14;
  // Control field positions and reset value.
  localparam int unsigned CTL_CLR_ERR  = 0;
  localparam int unsigned CTL_STRICT   = 1;
  localparam logic [1:0] CTL_RESET     = 2'h2;
  // Status field positions.
  localparam int unsigned ST_DONE      = 0;
  localparam int unsigned ST_ERR       = 1;
  localparam int unsigned ST_OCD       = 2;
  localparam int unsigned ST_CKE       = 3;
  localparam int unsigned ST_REF_LO    = 4;
  localparam int unsigned ST_STATE_LO  = 8;
  // Mode register fields.
  localparam int unsigned MR_DLL_RST   = 8;
  localparam int unsigned MR_TEST      = 7;
  localparam int unsigned EMR_OCD_LO   = 7;
  localparam logic [2:0] OCD_DEFAULT   = 3'h7;
  localparam logic [2:0] OCD_EXIT      = 3'h0;
  localparam logic [ADDR_W-1:0] MODE_RESET = 15'h0000;
  // Precharge-all flag on the address bus.
  localparam int unsigned PRE_ALL_BIT  = 10;
  // Mode register selects on BA1:BA0.
  localparam logic [1:0] SEL_MR        = 2'h0;
  localparam logic [1:0] SEL_EMR1      = 2'h1;
  localparam logic [1:0] SEL_EMR2      = 2'h2;
  localparam logic [1:0] SEL_EMR3      = 2'h3;
  // Timing.
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned CLK_MHZ       = 40;
  localparam int unsigned STABLE_US     = 200;
  localparam int unsigned STABLE_CYC    = STABLE_US * CLK_MHZ;
  localparam int unsigned CKE_NOP_NS    = 400;
  localparam int unsigned CKE_NOP_CYC   = (CKE_NOP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OCD_WAIT_CK   = 200;
  localparam int unsigned MIN_REFRESH   = 2;
  localparam int unsigned CNT_W         = 16;
  localparam int unsigned SYNC_STAGES   = 2;
endpackage

// ---- rtl/dram_cmd_if.sv ----
// Decoded command stream passed from the pin decoder to the sequence core.
`timescale 1ns/1ps
interface dram_cmd_if;
  import dram_init_pkg::*;
  logic              modeWrite;
  logic [1:0]        modeSel;
  logic [ADDR_W-1:0] modeData;
  logic              preAll;
  logic              refresh;
  logic              otherCmd;
  logic              ckeHigh;
  modport dec  (output modeWrite, modeSel, modeData, preAll, refresh, otherCmd, ckeHigh);
  modport core (input  modeWrite, modeSel, modeData, preAll, refresh, otherCmd, ckeHigh);
endinterface

// ---- rtl/dram_cmd_decode.sv ----
// Pin synchroniser and command decoder for the memory command bus.
`timescale 1ns/1ps
module dram_cmd_decode
  import dram_init_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              cke,
  input  wire logic              csN,
  input  wire logic              rasN,
  input  wire logic              casN,
  input  wire logic              weN,
  input  wire logic [2:0]        ba,
  input  wire logic [ADDR_W-1:0] addr,
  dram_cmd_if.dec                cmd
);
  localparam int unsigned PW = ADDR_W + 8;

  // Bits are synchronised one by one; a command is decoded again on every mclk edge that the bus holds it.
  logic [PW-1:0] meta_q, meta_d, pin_q, pin_d;
  logic          mw_d, pre_d, ref_d, oth_d, cke_d;
  logic          mw_q, pre_q, ref_q, oth_q, cke_q;
  logic [1:0]    sel_q, sel_d;
  logic [ADDR_W-1:0] dat_q, dat_d;
  logic          cmdSel, pinCke, pinRas, pinCas, pinWe;
  logic [2:0]    pinBa;
  logic [ADDR_W-1:0] pinAddr;

  always_comb begin
    meta_d  = {cke, csN, rasN, casN, weN, ba, addr};
    pin_d   = meta_q;
    {pinCke, cmdSel, pinRas, pinCas, pinWe, pinBa, pinAddr} = pin_q;
    cmdSel  = ~cmdSel;
    cke_d   = pinCke;
    mw_d    = pinCke & cmdSel & ~pinRas & ~pinCas & ~pinWe & ~pinBa[2];
    sel_d   = pinBa[1:0];
    dat_d   = pinAddr;
    pre_d   = pinCke & cmdSel & ~pinRas & pinCas & ~pinWe & pinAddr[PRE_ALL_BIT];
    ref_d   = pinCke & cmdSel & ~pinRas & ~pinCas & pinWe;
    oth_d   = pinCke & cmdSel & ~(mw_d | pre_d | ref_d) & ~(pinRas & pinCas & pinWe);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      pin_q  <= '0;
      mw_q   <= 1'b0;
      pre_q  <= 1'b0;
      ref_q  <= 1'b0;
      oth_q  <= 1'b0;
      cke_q  <= 1'b0;
      sel_q  <= 2'h0;
      dat_q  <= MODE_RESET;
    end else begin
      meta_q <= meta_d;
      pin_q  <= pin_d;
      mw_q   <= mw_d;
      pre_q  <= pre_d;
      ref_q  <= ref_d;
      oth_q  <= oth_d;
      cke_q  <= cke_d;
      sel_q  <= sel_d;
      dat_q  <= dat_d;
    end
  end

  assign cmd.modeWrite = mw_q;
  assign cmd.modeSel   = sel_q;
  assign cmd.modeData  = dat_q;
  assign cmd.preAll    = pre_q;
  assign cmd.refresh   = ref_q;
  assign cmd.otherCmd  = oth_q;
  assign cmd.ckeHigh   = cke_q;
endmodule

// ---- rtl/dram_power_up_init.sv ----
// Mode registers and power-up sequence tracker of the memory device.
`timescale 1ns/1ps
module dram_power_up_init
  import dram_init_pkg::*;
#(
  parameter int unsigned STABLE_CYCLES = STABLE_CYC
) (
  input  wire logic                                 mclk,
  input  wire logic                                 rst_n,
  input  wire logic                                 cke,
  input  wire logic                                 csN,
  input  wire logic                                 rasN,
  input  wire logic                                 casN,
  input  wire logic                                 weN,
  input  wire logic [2:0]                           ba,
  input  wire logic [dram_init_pkg::ADDR_W-1:0]     addr,
  input  wire logic [dram_init_pkg::REG_ADDR_W-1:0] regAddr,
  input  wire logic [dram_init_pkg::DATA_W-1:0]     regWdata,
  input  wire logic                                 regWr,
  input  wire logic                                 regRd,
  output logic      [dram_init_pkg::DATA_W-1:0]     regRdata,
  output logic                                      initDone,
  output logic                                      seqError,
  output logic                                      dllResetPulse,
  output logic                                      ocdCalActive
);
  import dram_init_pkg::*;

  typedef enum logic [3:0] {
    S_POWER, S_NOP_WAIT, S_PRE1, S_EMR2, S_EMR3, S_DLL_EN, S_DLL_RST, S_PRE2,
    S_REFRESH, S_OP_MRS, S_OCD_DEF, S_OCD_EXIT, S_READY
  } seq_t;

  dram_cmd_if cmd ();

  dram_cmd_decode u_decode (
    .mclk  (mclk),
    .rst_n (rst_n),
    .cke   (cke),
    .csN   (csN),
    .rasN  (rasN),
    .casN  (casN),
    .weN   (weN),
    .ba    (ba),
    .addr  (addr),
    .cmd   (cmd)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic [ADDR_W-1:0] mode_q [4];
  logic [ADDR_W-1:0] mode_d [4];
  logic [1:0]        ctl_q, ctl_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;

  // Array data is not modelled here, so a mode write cannot disturb it.
  generate
    for (genvar i = 0; i < 4; i++) begin : g_mode
      always_comb begin
        mode_d[i] = mode_q[i];
        if (cmd.modeWrite && cmd.modeSel == 2'(i)) begin
          mode_d[i] = cmd.modeData;
        end
      end
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          mode_q[i] <= MODE_RESET;
        end else begin
          mode_q[i] <= mode_d[i];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  seq_t             state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] dllCnt_q, dllCnt_d;
  logic [3:0]       refCnt_q, refCnt_d;
  logic             err_q, err_d;
  logic             done_q, done_d;
  logic             dllPulse_q, dllPulse_d;
  logic             ocd_q, ocd_d;
  logic             bad, strict;
  logic [2:0]       ocdBits;

  assign strict  = ctl_q[CTL_STRICT];
  assign ocdBits = cmd.modeData[EMR_OCD_LO +: 3];

  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    dllCnt_d   = dllCnt_q;
    refCnt_d   = refCnt_q;
    done_d     = done_q;
    ocd_d      = ocd_q;
    dllPulse_d = 1'b0;
    bad        = 1'b0;
    if (dllCnt_q != '1) begin
      dllCnt_d = dllCnt_q + 1'b1;
    end
    if (cmd.modeWrite && cmd.modeSel == SEL_MR && cmd.modeData[MR_DLL_RST]) begin
      dllPulse_d = 1'b1;
      dllCnt_d   = '0;
    end
    if (cmd.modeWrite && cmd.modeSel == SEL_MR && cmd.modeData[MR_TEST]) begin
      bad = 1'b1;
    end
    case (state_q)
      S_POWER: begin
        if (cnt_q != '1) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (cmd.ckeHigh) begin
          bad     = (32'(cnt_q) < STABLE_CYCLES);
          cnt_d   = '0;
          state_d = S_NOP_WAIT;
        end
      end
      S_NOP_WAIT: begin
        if (cnt_q != '1) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (cmd.modeWrite || cmd.refresh || cmd.otherCmd) begin
          bad = 1'b1;
        end else if (cmd.preAll) begin
          // The count starts one edge after the clock enable is seen, so one less is legal.
          bad     = (32'(cnt_q) < CKE_NOP_CYC - 1);
          state_d = S_EMR2;
        end
      end
      S_EMR2, S_EMR3, S_DLL_EN, S_DLL_RST, S_OP_MRS, S_OCD_DEF, S_OCD_EXIT: begin
        if (cmd.preAll || cmd.refresh || cmd.otherCmd) begin
          bad = 1'b1;
        end else if (cmd.modeWrite) begin
          state_d = seq_t'(state_q + 4'h1);
          case (state_q)
            S_EMR2:    bad = (cmd.modeSel != SEL_EMR2);
            S_EMR3:    bad = (cmd.modeSel != SEL_EMR3);
            S_DLL_EN:  bad = (cmd.modeSel != SEL_EMR1) || cmd.modeData[0];
            S_DLL_RST: bad = (cmd.modeSel != SEL_MR) || !cmd.modeData[MR_DLL_RST];
            S_OP_MRS:  bad = (cmd.modeSel != SEL_MR) || cmd.modeData[MR_DLL_RST];
            S_OCD_DEF: begin
              bad   = (cmd.modeSel != SEL_EMR1) || (ocdBits != OCD_DEFAULT)
                      || (32'(dllCnt_q) < OCD_WAIT_CK - 1);
              ocd_d = 1'b1;
            end
            default: begin
              bad    = (cmd.modeSel != SEL_EMR1) || (ocdBits != OCD_EXIT);
              ocd_d  = 1'b0;
              done_d = 1'b1;
            end
          endcase
          if (state_q == S_DLL_RST) begin
            state_d = S_PRE1;
          end
        end
      end
      S_PRE1: begin
        // Second precharge-all after the DLL reset write.
        if (cmd.preAll) begin
          state_d  = S_REFRESH;
          refCnt_d = '0;
        end else if (cmd.modeWrite || cmd.refresh || cmd.otherCmd) begin
          bad = 1'b1;
        end
      end
      S_REFRESH: begin
        if (cmd.refresh) begin
          if (refCnt_q != '1) begin
            refCnt_d = refCnt_q + 1'b1;
          end
        end else if (cmd.modeWrite) begin
          bad     = (32'(refCnt_q) < MIN_REFRESH) || (cmd.modeSel != SEL_MR)
                    || cmd.modeData[MR_DLL_RST];
          state_d = S_OCD_DEF;
        end else if (cmd.preAll || cmd.otherCmd) begin
          bad = 1'b1;
        end
      end
      S_READY: begin
        // Re-programming is allowed any time, but an MR write with the test bit set still faults; registers simply follow.
      end
      default: state_d = S_POWER;
    endcase
    if (state_q != S_READY && cmd.otherCmd) begin
      bad = 1'b1;
    end
    if (done_d && state_q == S_OCD_EXIT) begin
      state_d = S_READY;
    end
    // A new fault wins over a software clear in the same cycle.
    err_d = (err_q && !(regWr && regAddr == OFS_CONTROL && regWdata[CTL_CLR_ERR]))
            || (bad && strict);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= S_POWER;
      cnt_q      <= '0;
      dllCnt_q   <= '1;
      refCnt_q   <= 4'h0;
      err_q      <= 1'b0;
      done_q     <= 1'b0;
      dllPulse_q <= 1'b0;
      ocd_q      <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      dllCnt_q   <= dllCnt_d;
      refCnt_q   <= refCnt_d;
      err_q      <= err_d;
      done_q     <= done_d;
      dllPulse_q <= dllPulse_d;
      ocd_q      <= ocd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ctl_d   = ctl_q;
    rdata_d = '0;
    if (regWr && regAddr == OFS_CONTROL) begin
      ctl_d = {regWdata[CTL_STRICT], 1'b0};
    end
    if (regRd) begin
      case (regAddr)
        OFS_MR:      rdata_d = DATA_W'(mode_q[SEL_MR]);
        OFS_EMR1:    rdata_d = DATA_W'(mode_q[SEL_EMR1]);
        OFS_EMR2:    rdata_d = DATA_W'(mode_q[SEL_EMR2]);
        OFS_EMR3:    rdata_d = DATA_W'(mode_q[SEL_EMR3]);
        OFS_CONTROL: rdata_d = DATA_W'(ctl_q);
        OFS_STATUS: begin
          rdata_d[ST_DONE]                = done_q;
          rdata_d[ST_ERR]                 = err_q;
          rdata_d[ST_OCD]                 = ocd_q;
          rdata_d[ST_CKE]                 = cmd.ckeHigh;
          rdata_d[ST_REF_LO +: 4]         = refCnt_q;
          rdata_d[ST_STATE_LO +: 4]       = state_q;
        end
        default:     rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctl_q   <= CTL_RESET;
      rdata_q <= '0;
    end else begin
      ctl_q   <= ctl_d;
      rdata_q <= rdata_d;
    end
  end

  assign regRdata      = rdata_q;
  assign initDone      = done_q;
  assign seqError      = err_q;
  assign dllResetPulse = dllPulse_q;
  assign ocdCalActive  = ocd_q;
endmodule

// ---- dv/init_check_sva.sv ----
// Port-level assertions for the power-up tracker, bound to its top module.
`timescale 1ns/1ps
module init_check_sva #(
  parameter int unsigned STABLE_CYCLES = dram_init_pkg::STABLE_CYC
) (
  input wire logic                                 mclk,
  input wire logic                                 rst_n,
  input wire logic                                 cke,
  input wire logic                                 csN,
  input wire logic                                 rasN,
  input wire logic                                 casN,
  input wire logic                                 weN,
  input wire logic [2:0]                           ba,
  input wire logic [dram_init_pkg::ADDR_W-1:0]     addr,
  input wire logic [dram_init_pkg::REG_ADDR_W-1:0] regAddr,
  input wire logic [dram_init_pkg::DATA_W-1:0]     regWdata,
  input wire logic                                 regWr,
  input wire logic                                 regRd,
  input wire logic [dram_init_pkg::DATA_W-1:0]     regRdata,
  input wire logic                                 initDone,
  input wire logic                                 seqError,
  input wire logic                                 dllResetPulse,
  input wire logic                                 ocdCalActive
);
  import dram_init_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // A new fault beats a clear in the same cycle, so only a clear may drop the flag.
  wire logic ctlClear = regWr && regAddr == OFS_CONTROL && regWdata[CTL_CLR_ERR];
  default clocking dc @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence dllMrs_s;
    cke && !csN && !rasN && !casN && !weN && ba == 3'h0 && addr[MR_DLL_RST];
  endsequence
  sequence statusRead_s;
    regRd && regAddr == OFS_STATUS;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  dll_pulse_follows_a: assert property (dllMrs_s |-> ##[2:5] dllResetPulse)
    else $error("DLL reset write gave no pulse");
  dll_pulse_single_a: assert property (dllResetPulse |=> !dllResetPulse)
    else $error("DLL reset pulse longer than one cycle");
  no_cke_cmd_a: assert property (!cke [*6] |-> !dllResetPulse)
    else $error("Command decoded while clock enable low");
  done_sticky_a: assert property (initDone |=> initDone)
    else $error("Ready flag dropped");
  done_after_ocd_a: assert property ($rose(initDone) |-> $past(ocdCalActive))
    else $error("Ready without calibration exit");
  ocd_not_done_a: assert property (ocdCalActive |-> !initDone)
    else $error("Calibration active after ready");
  err_sticky_a: assert property (seqError && !ctlClear |=> seqError)
    else $error("Fault flag dropped without clear");
  status_view_a: assert property (statusRead_s |=> regRdata[ST_DONE] == $past(initDone)
    && regRdata[ST_ERR] == $past(seqError))
    else $error("Status read disagrees with flags");
  rdata_idle_a: assert property (!regRd |=> regRdata == '0)
    else $error("Read data outside read cycle");
endmodule
bind dram_power_up_init init_check_sva #(.STABLE_CYCLES(STABLE_CYCLES)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
  .weN(weN), .ba(ba), .addr(addr), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .initDone(initDone),
  .seqError(seqError), .dllResetPulse(dllResetPulse), .ocdCalActive(ocdCalActive)
);

// ---- dv/mem_ctrl_model.sv ----
// Behavioural memory controller driving the command pins of the device.
`timescale 1ns/1ps
module mem_ctrl_model (
  input  wire logic                        mclk,
  output logic                             cke,
  output logic                             csN,
  output logic                             rasN,
  output logic                             casN,
  output logic                             weN,
  output logic [2:0]                       ba,
  output logic [dram_init_pkg::ADDR_W-1:0] addr
);
  import dram_init_pkg::*;
  // Clock enable low and chip deselected while supplies ramp.
  initial begin
    {cke, csN, rasN, casN, weN} = 5'h0F;
    ba = 3'h0;
    addr = '0;
  end
  task automatic set_cke(input logic v);
    @(posedge mclk);
    cke <= v;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // Unused lines flip after the command so a stale value can never decode.
  task automatic issue(input logic [3:0] pins, input logic [2:0] b, input logic [ADDR_W-1:0] a);
    @(posedge mclk);
    {csN, rasN, casN, weN} <= pins;
    ba <= b;
    addr <= a;
    @(posedge mclk);
    {csN, rasN, casN, weN} <= 4'h7;
    ba <= ~b;
    addr <= ~a;
    repeat (4) @(posedge mclk);
    #1;
  endtask
endmodule

// ---- dv/tb.sv ----
// Self-checking bench: power-up order, mode registers and the fault flag.
`timescale 1ns/1ps
module tb;
  import dram_init_pkg::*;
  localparam int unsigned       STABLE_TEST = 20;
  localparam logic [3:0]        CMD_MODE = 4'h0;
  localparam logic [3:0]        CMD_REF = 4'h1;
  localparam logic [3:0]        CMD_PRE = 4'h2;
  localparam logic [3:0]        CMD_READ = 4'h5;
  localparam logic [ADDR_W-1:0] PRE_ALL = 15'h0400;
  // Masks keep A7 and A8 low in MR, and OCD bits and DLL enable clear in EMR1.
  localparam logic [ADDR_W-1:0] MR_MASK = 15'h7E7F;
  localparam logic [ADDR_W-1:0] E1_MASK = 15'h7C7E;
  logic                  mclk, rst_n, cke, csN, rasN, casN, weN, regWr, regRd;
  logic                  initDone, seqError, dllResetPulse, ocdCalActive;
  logic [2:0]            ba;
  logic [ADDR_W-1:0]     addr;
  logic [REG_ADDR_W-1:0] regAddr;
  logic [DATA_W-1:0]     regWdata, regRdata, got;
  logic [15:0]           lfsr;
  int                    errTotal, totalChecks;
  dram_power_up_init #(.STABLE_CYCLES(STABLE_TEST)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
    .weN(weN), .ba(ba), .addr(addr), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .initDone(initDone),
    .seqError(seqError), .dllResetPulse(dllResetPulse), .ocdCalActive(ocdCalActive)
  );
  mem_ctrl_model u_ctrl (
    .mclk(mclk), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
    .ba(ba), .addr(addr)
  );
  initial mclk = 1'b0;
  always #(CLK_PERIOD_NS / 2.0) mclk = ~mclk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [ADDR_W-1:0] rnd15();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[ADDR_W-1:0];
  endfunction
  function automatic logic [DATA_W-1:0] status_exp(input logic d, input logic e, input logic k,
                                                   input logic [3:0] r);
    return (DATA_W'(d) << ST_DONE) | (DATA_W'(e) << ST_ERR) | (DATA_W'(k) << ST_CKE)
           | (DATA_W'(r) << ST_REF_LO);
  endfunction
  task automatic check_reg(input string what, input logic [DATA_W-1:0] exp,
                           input logic [DATA_W-1:0] seen);
    totalChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic check_flag(input string what, input logic exp, input logic seen);
    totalChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("Error %s expected %b seen %b", what, exp, seen);
    end
  endtask
  task automatic reg_write(input logic [REG_ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge mclk);
    regWr <= 1'b0;
    #1;
  endtask
  task automatic reg_read(input logic [REG_ADDR_W-1:0] a);
    @(posedge mclk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 got = regRdata;
  endtask
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
  endtask
  task automatic mode_write(input logic [1:0] sel, input logic [ADDR_W-1:0] val);
    u_ctrl.issue(CMD_MODE, {1'b0, sel}, val);
    reg_read({4'h0, sel, 2'h0});
    check_reg("mode register", DATA_W'(val), got);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge mclk);
    errTotal++;
    $display("Error watchdog expected finish seen timeout");
    report_and_stop();
  end
  initial begin
    {rst_n, regWr, regRd} = 3'h0;
    regAddr = '0;
    regWdata = '0;
    lfsr = 16'h000A;
    errTotal = 0;
    totalChecks = 0;
    do_reset();
    for (int i = 0; i < 4; i++) begin
      reg_read(REG_ADDR_W'(4 * i));
      check_reg("mode reset", DATA_W'(MODE_RESET), got);
    end
    reg_read(OFS_CONTROL);
    check_reg("control reset", DATA_W'(CTL_RESET), got);
    reg_write(8'h20, '1);
    reg_read(8'h20);
    check_reg("unmapped", '0, got);
    u_ctrl.idle(STABLE_TEST + 5);
    u_ctrl.set_cke(1'b1);
    // Precharge lands exactly at the shortest legal wait after the clock enable.
    u_ctrl.idle(CKE_NOP_CYC - 1);
    u_ctrl.issue(CMD_PRE, 3'h0, PRE_ALL);
    mode_write(SEL_EMR2, rnd15());
    mode_write(SEL_EMR3, rnd15());
    mode_write(SEL_EMR1, rnd15() & E1_MASK);
    mode_write(SEL_MR, (rnd15() & MR_MASK) | 15'h0100);
    u_ctrl.issue(CMD_PRE, 3'h0, PRE_ALL);
    repeat (MIN_REFRESH) u_ctrl.issue(CMD_REF, 3'h0, rnd15());
    mode_write(SEL_MR, rnd15() & MR_MASK);
    u_ctrl.idle(OCD_WAIT_CK);
    mode_write(SEL_EMR1, (rnd15() & E1_MASK) | 15'h0380);
    check_flag("ocd active", 1'b1, ocdCalActive);
    check_flag("ready early", 1'b0, initDone);
    mode_write(SEL_EMR1, rnd15() & E1_MASK);
    check_flag("ready", 1'b1, initDone);
    check_flag("fault", 1'b0, seqError);
    reg_read(OFS_STATUS);
    check_reg("status", status_exp(1'b1, 1'b0, 1'b1, 4'(MIN_REFRESH)), got & 32'hFF);
    // Re-programming after ready must keep the device ready and fault-free.
    mode_write(SEL_EMR3, rnd15());
    mode_write(SEL_MR, (rnd15() & MR_MASK) | 15'h0100);
    u_ctrl.issue(CMD_READ, 3'h0, rnd15());
    check_flag("ready kept", 1'b1, initDone);
    check_flag("fault", 1'b0, seqError);
    u_ctrl.set_cke(1'b0);
    do_reset();
    u_ctrl.issue(CMD_MODE, 3'h0, 15'h0155);
    reg_read(OFS_MR);
    check_reg("ignored write", '0, got);
    u_ctrl.set_cke(1'b1);
    u_ctrl.idle(4);
    check_flag("early cke", 1'b1, seqError);
    reg_write(OFS_CONTROL, 32'h00000003);
    check_flag("cleared", 1'b0, seqError);
    u_ctrl.issue(CMD_READ, 3'h0, rnd15());
    check_flag("early command", 1'b1, seqError);
    reg_write(OFS_CONTROL, 32'h00000001);
    reg_read(OFS_CONTROL);
    check_reg("control", '0, got);
    u_ctrl.issue(CMD_READ, 3'h0, rnd15());
    check_flag("relaxed", 1'b0, seqError);
    // A mode write with the third bank bit set is some other command and must not land.
    u_ctrl.issue(CMD_MODE, 3'h4, 15'h0155);
    reg_read(OFS_MR);
    check_reg("bank two write", '0, got);
    report_and_stop();
  end
endmodule
